// File: core/rlfs_defs.vh
// Constants for the rail limit, frequency and slew configuration bank
// Contract
// - Rails 3-5: bit 0 trips at 16, 1 disables
// - Rail 4 limit codes select 3.5/4/4.5/5 A
// - Linear regulator limit: 0 is 1A, 1 is 1.5A
// - Frequency codes select 600k/800k/1M/1.2M Hz
// - Full ratio slew: 0.25/0.5/1/5 mV per us
// - Half ratio slew doubles: 0.5/1/2/10 mV/us
// - Rails 1-4 use ratio bits 7,6,5,4
// - Rail 5 uses ratio bit 3
// - Rail five register bits 3:0 are reserved
// - Rails 1-2 trip at 16 or disable
`ifndef RLFS_DEFS_VH
`define RLFS_DEFS_VH
`define RLFS_ADDR_OC_CFG0 8'h5c
`define RLFS_ADDR_OC_CFG1 8'h5d
`define RLFS_ADDR_FS_CFG0 8'h5e
`define RLFS_ADDR_FS_CFG1 8'h5f
`define RLFS_ADDR_FS_CFG2 8'h60
`define RLFS_ADDR_FB_RATIO 8'h76
`define RLFS_RST_OC_CFG0 8'h00
`define RLFS_RST_OC_CFG1 8'h00
`define RLFS_RST_FS_CFG0 8'h00
`define RLFS_RST_FS_CFG1 8'h00
`define RLFS_RST_FS_CFG2 8'h00
`define RLFS_FS2_RSVD_MASK 8'hf0
`define RLFS_TRIP_RUN 5'h10
// Field positions in the upper overcurrent register
`define RLFS_TRIP_R3_BIT 7
`define RLFS_LIM_R4_HI 6
`define RLFS_TRIP_R4_BIT 4
`define RLFS_LIM_R5_HI 3
`define RLFS_TRIP_R5_BIT 1
`define RLFS_LIM_LR_BIT 0
// Field positions in the lower overcurrent register
`define RLFS_LIM_R1_HI 7
`define RLFS_TRIP_R1_BIT 5
`define RLFS_LIM_R2_HI 4
`define RLFS_TRIP_R2_BIT 2
`define RLFS_LIM_R3_HI 1
// Field positions in the frequency and slew registers
`define RLFS_FREQ_A_HI 7
`define RLFS_SLEW_A_HI 5
`define RLFS_FREQ_B_HI 3
`define RLFS_SLEW_B_HI 1
// Ratio bit of each rail in the feedback ratio register
`define RLFS_HALF_R1_BIT 7
`define RLFS_HALF_R2_BIT 6
`define RLFS_HALF_R3_BIT 5
`define RLFS_HALF_R4_BIT 4
`define RLFS_HALF_R5_BIT 3
// Limits in mA, frequencies in kHz, slews in uV/us
`define RLFS_LIM_R4_BASE 16'd3500
`define RLFS_LIM_STEP 16'd500
`define RLFS_LIM_LR_LO 16'd1000
`define RLFS_LIM_LR_HI 16'd1500
`define RLFS_FREQ_BASE 12'd600
`define RLFS_FREQ_STEP 12'd200
`define RLFS_SLEW_C0 16'd250
`define RLFS_SLEW_C1 16'd500
`define RLFS_SLEW_C2 16'd1000
`define RLFS_SLEW_C3 16'd5000
`endif

// File: core/rlfs_trip_counter.v
// Consecutive over-limit switching cycle counter for one rail
`default_nettype none
module rlfs_trip_counter #(
   parameter RUN_LEN = 16
) (
   // Clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // Rail cycle events, same clock domain
   input wire cycle_done_in,
   input wire over_limit_in,
   input wire protect_off_in,
   // Trip result
   output reg trip_out
);
   reg [4:0] run;

   // Run length, restarted by any clean cycle
   always @(posedge ref_clk_in) begin
      if (rst_in || protect_off_in) begin
         run <= 5'h00;
         trip_out <= 1'b0;
      end else if (cycle_done_in) begin
         if (!over_limit_in) begin
            run <= 5'h00;
         end else if (run == RUN_LEN[4:0] - 5'h01) begin
            run <= 5'h00;
            trip_out <= 1'b1;
         end else begin
            run <= run + 5'h01;
         end
      end
   end
endmodule // rlfs_trip_counter
`default_nettype wire

// File: core/rlfs_cfg_bank.v
// Overcurrent, switching frequency and slew configuration register bank
`default_nettype none
`include "rlfs_defs.vh"
module rlfs_cfg_bank #(
   parameter NRAIL = 5
) (
   // Clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // Register access port from the serial management logic
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   output reg [7:0] reg_rdata_out,
   output wire reg_hit_out,
   // Feedback ratio register, held elsewhere
   input wire [7:0] fb_ratio_in,
   // Switching cycle events per rail, bit 0 is rail one
   input wire [NRAIL-1:0] cycle_done_in,
   input wire [NRAIL-1:0] over_limit_in,
   // Settings to the regulators
   output wire [NRAIL-1:0] protect_off_out,
   output wire [NRAIL-1:0] oc_trip_out,
   output reg [15:0] limit_r4_ma_out,
   output reg [15:0] limit_r5_ma_out,
   output reg [15:0] limit_lr_ma_out,
   output reg [12*NRAIL-1:0] freq_khz_out,
   output reg [16*NRAIL-1:0] slew_uv_us_out,
   output reg [NRAIL-1:0] feedback_half_out
);
   reg [7:0] oc_cfg_lower_rails;
   reg [7:0] overcurrent_cfg_upper_rails;
   reg [7:0] freq_slew_cfg_rails_one_two;
   reg [7:0] freq_slew_cfg_rails_three_four;
   reg [7:0] freq_slew_cfg_rail_five;
   reg [1:0] freq_code [0:NRAIL-1];
   reg [1:0] slew_code [0:NRAIL-1];
   integer i;

   // Slew rate in uV/us, doubled at half ratio
   function [15:0] slew_of;
      input [1:0] code;
      input half;
      reg [15:0] base;
      begin
         case (code)
            2'h0: base = `RLFS_SLEW_C0;
            2'h1: base = `RLFS_SLEW_C1;
            2'h2: base = `RLFS_SLEW_C2;
            default: base = `RLFS_SLEW_C3;
         endcase
         slew_of = half ? {base[14:0], 1'b0} : base;
      end
   endfunction

   // Limit of a 500 mA step field
   function [15:0] limit_of;
      input [1:0] code;
      input [15:0] base;
      begin
         limit_of = base + `RLFS_LIM_STEP * {14'h0000, code};
      end
   endfunction

   // True for the five addresses this bank answers
   function reg_mapped;
      input [7:0] addr;
      begin
         reg_mapped = (addr == `RLFS_ADDR_OC_CFG0) ||
            (addr == `RLFS_ADDR_OC_CFG1) ||
            (addr == `RLFS_ADDR_FS_CFG0) ||
            (addr == `RLFS_ADDR_FS_CFG1) ||
            (addr == `RLFS_ADDR_FS_CFG2);
      end
   endfunction

   // Same decode as the write gate, so hit and write never disagree
   assign reg_hit_out = reg_mapped(reg_addr_in);

   // Register writes; unmapped addresses are ignored
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         oc_cfg_lower_rails <= `RLFS_RST_OC_CFG0;
         overcurrent_cfg_upper_rails <= `RLFS_RST_OC_CFG1;
         freq_slew_cfg_rails_one_two <= `RLFS_RST_FS_CFG0;
         freq_slew_cfg_rails_three_four <= `RLFS_RST_FS_CFG1;
         freq_slew_cfg_rail_five <= `RLFS_RST_FS_CFG2;
      end else if (reg_wr_in && reg_mapped(reg_addr_in)) begin
         case (reg_addr_in)
            `RLFS_ADDR_OC_CFG0: oc_cfg_lower_rails <= reg_wdata_in;
            `RLFS_ADDR_OC_CFG1: begin
               // Code 11b on rail five stored as written; host must avoid it
               overcurrent_cfg_upper_rails <= reg_wdata_in;
            end
            `RLFS_ADDR_FS_CFG0: freq_slew_cfg_rails_one_two <= reg_wdata_in;
            `RLFS_ADDR_FS_CFG1: begin
               freq_slew_cfg_rails_three_four <= reg_wdata_in;
            end
            `RLFS_ADDR_FS_CFG2: begin
               // Reserved low nibble kept at zero
               freq_slew_cfg_rail_five <=
                  reg_wdata_in & `RLFS_FS2_RSVD_MASK;
            end
            default: ;
         endcase
      end
   end

   // Registered read data
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         case (reg_addr_in)
            `RLFS_ADDR_OC_CFG0: reg_rdata_out <= oc_cfg_lower_rails;
            `RLFS_ADDR_OC_CFG1: reg_rdata_out <= overcurrent_cfg_upper_rails;
            `RLFS_ADDR_FS_CFG0: reg_rdata_out <= freq_slew_cfg_rails_one_two;
            `RLFS_ADDR_FS_CFG1: begin
               reg_rdata_out <= freq_slew_cfg_rails_three_four;
            end
            `RLFS_ADDR_FS_CFG2: reg_rdata_out <= freq_slew_cfg_rail_five;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // Overcurrent fields, named once so every decoder reads the same bits
   wire trip_cycles_sel_r1 = oc_cfg_lower_rails[`RLFS_TRIP_R1_BIT];
   wire trip_cycles_sel_r2 = oc_cfg_lower_rails[`RLFS_TRIP_R2_BIT];
   wire trip_cycles_sel_r3 = overcurrent_cfg_upper_rails[`RLFS_TRIP_R3_BIT];
   wire trip_cycles_sel_r4 = overcurrent_cfg_upper_rails[`RLFS_TRIP_R4_BIT];
   wire trip_cycles_sel_r5 = overcurrent_cfg_upper_rails[`RLFS_TRIP_R5_BIT];
   wire [1:0] current_limit_r4 =
      overcurrent_cfg_upper_rails[`RLFS_LIM_R4_HI -: 2];
   // Code 11b here still decodes to 5 A; only the host keeps it away
   wire [1:0] current_limit_r5 =
      overcurrent_cfg_upper_rails[`RLFS_LIM_R5_HI -: 2];
   wire current_limit_linear_reg =
      overcurrent_cfg_upper_rails[`RLFS_LIM_LR_BIT];

   // Frequency and slew fields, two rails to a register except rail five, which has its own
   wire [1:0] switch_freq_r1 =
      freq_slew_cfg_rails_one_two[`RLFS_FREQ_A_HI -: 2];
   wire [1:0] volt_ramp_rate_r1 =
      freq_slew_cfg_rails_one_two[`RLFS_SLEW_A_HI -: 2];
   wire [1:0] switch_freq_r2 =
      freq_slew_cfg_rails_one_two[`RLFS_FREQ_B_HI -: 2];
   wire [1:0] volt_ramp_rate_r2 =
      freq_slew_cfg_rails_one_two[`RLFS_SLEW_B_HI -: 2];
   wire [1:0] switch_freq_r3 =
      freq_slew_cfg_rails_three_four[`RLFS_FREQ_A_HI -: 2];
   wire [1:0] volt_ramp_rate_r3 =
      freq_slew_cfg_rails_three_four[`RLFS_SLEW_A_HI -: 2];
   wire [1:0] switch_freq_r4 =
      freq_slew_cfg_rails_three_four[`RLFS_FREQ_B_HI -: 2];
   wire [1:0] volt_ramp_rate_r4 =
      freq_slew_cfg_rails_three_four[`RLFS_SLEW_B_HI -: 2];
   wire [1:0] switch_freq_r5 =
      freq_slew_cfg_rail_five[`RLFS_FREQ_A_HI -: 2];
   wire [1:0] volt_ramp_rate_r5 =
      freq_slew_cfg_rail_five[`RLFS_SLEW_A_HI -: 2];

   // Ratio bit per rail, 1 selects half feedback
   wire feedback_half_r1 = fb_ratio_in[`RLFS_HALF_R1_BIT];
   wire feedback_half_r2 = fb_ratio_in[`RLFS_HALF_R2_BIT];
   wire feedback_half_r3 = fb_ratio_in[`RLFS_HALF_R3_BIT];
   wire feedback_half_r4 = fb_ratio_in[`RLFS_HALF_R4_BIT];
   wire feedback_half_r5 = fb_ratio_in[`RLFS_HALF_R5_BIT];
   wire [NRAIL-1:0] half_sel = {feedback_half_r5, feedback_half_r4,
      feedback_half_r3, feedback_half_r2, feedback_half_r1};

   // Per-rail frequency and slew code fields
   always @* begin
      freq_code[0] = switch_freq_r1;
      slew_code[0] = volt_ramp_rate_r1;
      freq_code[1] = switch_freq_r2;
      slew_code[1] = volt_ramp_rate_r2;
      freq_code[2] = switch_freq_r3;
      slew_code[2] = volt_ramp_rate_r3;
      freq_code[3] = switch_freq_r4;
      slew_code[3] = volt_ramp_rate_r4;
      freq_code[4] = switch_freq_r5;
      slew_code[4] = volt_ramp_rate_r5;
   end

   // Protection disable bits, rails one to five
   assign protect_off_out = {
      trip_cycles_sel_r5,
      trip_cycles_sel_r4,
      trip_cycles_sel_r3,
      trip_cycles_sel_r2,
      trip_cycles_sel_r1
   };

   // One run counter per rail
   genvar g;
   generate
      for (g = 0; g < NRAIL; g = g + 1) begin : g_trip
         rlfs_trip_counter #(
            .RUN_LEN(`RLFS_TRIP_RUN)
         ) u_cnt (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .cycle_done_in(cycle_done_in[g]),
            .over_limit_in(over_limit_in[g]),
            .protect_off_in(protect_off_out[g]),
            .trip_out(oc_trip_out[g])
         );
      end
   endgenerate

   // Decoded settings, registered so outputs come from flip-flops
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         limit_r4_ma_out <= `RLFS_LIM_R4_BASE;
         limit_r5_ma_out <= `RLFS_LIM_R4_BASE;
         limit_lr_ma_out <= `RLFS_LIM_LR_LO;
         freq_khz_out <= {(12*NRAIL){1'b0}};
         slew_uv_us_out <= {(16*NRAIL){1'b0}};
         feedback_half_out <= {NRAIL{1'b0}};
      end else begin
         limit_r4_ma_out <= limit_of(current_limit_r4,
            `RLFS_LIM_R4_BASE);
         limit_r5_ma_out <= limit_of(current_limit_r5,
            `RLFS_LIM_R4_BASE);
         limit_lr_ma_out <= current_limit_linear_reg ?
            `RLFS_LIM_LR_HI : `RLFS_LIM_LR_LO;
         for (i = 0; i < NRAIL; i = i + 1) begin
            // Ratio sampled with the code, so slew and flag agree
            feedback_half_out[i] <= half_sel[i];
            freq_khz_out[12*i +: 12] <= `RLFS_FREQ_BASE +
               `RLFS_FREQ_STEP * {10'h000, freq_code[i]};
            slew_uv_us_out[16*i +: 16] <=
               slew_of(slew_code[i], half_sel[i]);
         end
      end
   end
endmodule // rlfs_cfg_bank
`default_nettype wire

// File: bench/rlfs_cfg_props.sv
// Port assertions for the configuration bank
`default_nettype none
`include "rlfs_defs.vh"
module rlfs_cfg_props #(parameter NRAIL = 5) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_rdata_out,
   // Rail side
   input wire logic [7:0] fb_ratio_in,
   input wire logic [NRAIL-1:0] cycle_done_in,
   input wire logic [NRAIL-1:0] over_limit_in,
   input wire logic [NRAIL-1:0] protect_off_out,
   input wire logic [NRAIL-1:0] oc_trip_out,
   input wire logic [15:0] limit_r4_ma_out,
   input wire logic [15:0] limit_lr_ma_out,
   input wire logic [12*NRAIL-1:0] freq_khz_out,
   input wire logic [16*NRAIL-1:0] slew_uv_us_out,
   input wire logic [NRAIL-1:0] feedback_half_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // Ratio bits in rail order, rail one lowest
   wire logic [4:0] fb_rev = {fb_ratio_in[3], fb_ratio_in[4],
      fb_ratio_in[5], fb_ratio_in[6], fb_ratio_in[7]};
   // Full ratio slew table
   function automatic logic [15:0] sl(input logic [1:0] c);
      return c[1] ? (c[0] ? `RLFS_SLEW_C3 : `RLFS_SLEW_C2) :
         (c[0] ? `RLFS_SLEW_C1 : `RLFS_SLEW_C0);
   endfunction
   // Write accepted at one address
   sequence s_wr(logic [7:0] a);
      reg_wr_in && reg_addr_in == a;
   endsequence
   a_lim_r4_decode: assert property (s_wr(8'h5d) |-> ##2
      limit_r4_ma_out == `RLFS_LIM_R4_BASE + `RLFS_LIM_STEP *
      $past(reg_wdata_in[6:5], 2)) else $error("rail four limit wrong");
   a_lim_lr_decode: assert property (s_wr(8'h5d) |-> ##2
      limit_lr_ma_out == ($past(reg_wdata_in[0], 2) ? `RLFS_LIM_LR_HI :
      `RLFS_LIM_LR_LO)) else $error("linear limit wrong");
   a_freq_r1_decode: assert property (s_wr(8'h5e) |-> ##2
      freq_khz_out[11:0] == `RLFS_FREQ_BASE + `RLFS_FREQ_STEP *
      $past(reg_wdata_in[7:6], 2)) else $error("rail one freq wrong");
   a_slew_r1_ratio: assert property (s_wr(8'h5e) |-> ##2
      slew_uv_us_out[15:0] == sl($past(reg_wdata_in[5:4], 2)) <<
      $past(fb_ratio_in[7])) else $error("rail one slew wrong");
   a_half_bits_track: assert property (!$past(rst_in) |->
      feedback_half_out == $past(fb_rev)) else $error("ratio copy wrong");
   a_rsvd_read_zero: assert property (reg_addr_in == 8'h60 |=>
      reg_rdata_out[3:0] == 4'h0) else $error("reserved bits read");
   a_off_follows_wr: assert property (s_wr(8'h5d) |=>
      protect_off_out[2] == $past(reg_wdata_in[7]))
      else $error("rail three disable wrong");
   a_trip_needs_over: assert property ($rose(oc_trip_out[2]) |->
      $past(cycle_done_in[2]) && $past(over_limit_in[2]))
      else $error("trip without over limit cycle");
   a_trip_clears_off: assert property (protect_off_out[0] |=>
      !oc_trip_out[0]) else $error("trip while disabled");
endmodule // rlfs_cfg_props
bind rlfs_cfg_bank rlfs_cfg_props #(.NRAIL(NRAIL)) i_props (.*);
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the configuration bank
`default_nettype none
`include "rlfs_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_hit_out;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic [7:0] fb_ratio_in = 8'h00;
   logic [4:0] cycle_done_in = 5'h00, over_limit_in = 5'h00;
   logic [4:0] protect_off_out, oc_trip_out, feedback_half_out;
   logic [15:0] limit_r4_ma_out, limit_r5_ma_out, limit_lr_ma_out;
   logic [59:0] freq_khz_out;
   logic [79:0] slew_uv_us_out;
   logic [15:0] slt [4] = '{`RLFS_SLEW_C0, `RLFS_SLEW_C1, `RLFS_SLEW_C2,
      `RLFS_SLEW_C3};
   int errors = 0, samples_checked = 0, cycles = 0;
   rlfs_cfg_bank i_dut (.*);
   always #5 ref_clk_in = ~ref_clk_in;
   task automatic chk(input string n, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   // One write strobe, then wait for the decoded outputs
   task automatic wr(input logic [7:0] a, d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      #1;
      chk("read data", e, reg_rdata_out);
   endtask
   // Switching cycles on rails one and three
   task automatic pulses(input int n, input logic ov);
      repeat (n) begin
         @(posedge ref_clk_in);
         cycle_done_in <= 5'h05;
         over_limit_in <= {5{ov}};
         @(posedge ref_clk_in);
         cycle_done_in <= 5'h00;
      end
      @(posedge ref_clk_in);
      #1;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Hang guard, far above the expected few hundred cycles
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         test_done;
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      for (int a = 8'h5c; a <= 8'h60; a++)
         rd(8'(a), 8'h00);
      chk("hit", 16'h0001, {15'h0, reg_hit_out});
      chk("limit lr", `RLFS_LIM_LR_LO, limit_lr_ma_out);
      chk("freq r3", `RLFS_FREQ_BASE, freq_khz_out[35:24]);
      rd(8'h70, 8'h00);
      chk("hit", 16'h0000, {15'h0, reg_hit_out});
      $display("reset test done");
      for (logic [2:0] c = 0; c < 4; c++) begin
         // Rail five limit code stays below 11b
         wr(8'h5d, {1'b0, c[1:0], 1'b0, c[1] & c[0] ? 2'b00 : c[1:0],
            1'b0, c[0]});
         chk("limit r4", `RLFS_LIM_R4_BASE + `RLFS_LIM_STEP * c,
            limit_r4_ma_out);
         chk("limit r5", c == 3 ? `RLFS_LIM_R4_BASE : `RLFS_LIM_R4_BASE +
            `RLFS_LIM_STEP * c, limit_r5_ma_out);
         chk("limit lr", c[0] ? `RLFS_LIM_LR_HI : `RLFS_LIM_LR_LO,
            limit_lr_ma_out);
      end
      $display("limit test done");
      for (logic [1:0] h = 0; h < 2; h++) begin
         // Alternate ratio bits so a swapped rail shows
         @(posedge ref_clk_in);
         fb_ratio_in <= h[0] ? 8'ha8 : 8'h50;
         for (logic [2:0] c = 0; c < 4; c++) begin
            wr(8'h5e, {c[1:0], c[1:0], 4'h0});
            wr(8'h5f, {4'h0, c[1:0], c[1:0]});
            wr(8'h60, {c[1:0], c[1:0], 4'hf});
            chk("freq r1", `RLFS_FREQ_BASE + `RLFS_FREQ_STEP * c,
               freq_khz_out[11:0]);
            chk("freq r5", `RLFS_FREQ_BASE + `RLFS_FREQ_STEP * c,
               freq_khz_out[59:48]);
            chk("freq r4", `RLFS_FREQ_BASE + `RLFS_FREQ_STEP * c,
               freq_khz_out[47:36]);
            chk("slew r1", slt[c] << h, slew_uv_us_out[15:0]);
            chk("slew r4", slt[c] << !h, slew_uv_us_out[63:48]);
            chk("slew r5", slt[c] << h, slew_uv_us_out[79:64]);
            rd(8'h60, {c[1:0], c[1:0], 4'h0});
            chk("half", h[0] ? 16'h15 : 16'h0a, feedback_half_out);
         end
      end
      $display("freq slew test done");
      pulses(15, 1'b1);
      pulses(1, 1'b0);
      pulses(15, 1'b1);
      chk("trip", 16'h0000, oc_trip_out);
      pulses(1, 1'b1);
      chk("trip", 16'h0005, oc_trip_out);
      wr(8'h5c, 8'h20);
      wr(8'h5d, 8'h80);
      chk("off", 16'h0005, protect_off_out);
      pulses(17, 1'b1);
      chk("trip", 16'h0000, oc_trip_out);
      wr(8'h5c, 8'h04);
      wr(8'h5d, 8'h12);
      chk("off", 16'h001a, protect_off_out);
      $display("trip test done");
      test_done;
   end
endmodule // tb_top
`default_nettype wire
